// file: src/light_value_readout.sv
`timescale 1ns/1ps
`include "light_readout_map.svh"
// What this block does
// - Command 5Ah returns raw value high byte.
// - Command 5Bh returns raw value low byte.
// - Command 5Ch returns filtered value high byte.
// - Reading one byte freezes its partner byte.
// - Reading both bytes releases the pair.
// - Repeated low read refreshes the high byte.
// - Repeated high read refreshes the low byte.
// - Any other command releases the pair.
// - Sensing disabled makes every byte read zero.
// - Values are full-range 16-bit unsigned.
// - 16-bit links put zero in upper byte.
module light_value_readout
   import light_readout_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic cmd_valid_in,
   input wire logic wide_link_in,
   input wire logic [15:0] cmd_code_in,
   input wire logic sense_enable_in,
   input wire logic [15:0] raw_sample_in,
   input wire logic raw_valid_in,
   input wire logic [15:0] filt_sample_in,
   input wire logic filt_valid_in,
   output logic rsp_valid_out,
   output logic [15:0] rsp_data_out
);
   // ****************************************************************
   // Command decode
   // ****************************************************************
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rsp_state_type;
   rsp_state_type cur;
   rsp_state_type next_cur;
   cmd_sel_type sel;
   logic [15:0] raw_value;
   logic [15:0] filt_value;
   logic [7:0] byte_pick;

   // Returns one byte of a held value; the high flag chooses the upper half.
   function automatic logic [7:0] pick_byte(input logic [15:0] value, input logic high);
      if (high) begin
         pick_byte = value[15:8];
      end else begin
         pick_byte = value[7:0];
      end
   endfunction : pick_byte

   // Maps a command code to the byte it selects, for either link width.
   function automatic cmd_sel_type decode(input logic wide, input logic [15:0] code);
      logic [7:0] op;
      op = wide ? code[15:8] : code[7:0];
      if (wide && code[7:0] != 8'h00) begin
         decode = sel_none_type;
      end else if (op == `CMD_RAW_HIGH_SHORT) begin
         decode = sel_raw_high_type;
      end else if (op == `CMD_RAW_LOW_SHORT) begin
         decode = sel_raw_low_type;
      end else if (op == `CMD_FILT_HIGH_SHORT) begin
         decode = sel_filt_high_type;
      end else if (op == `CMD_FILT_LOW_SHORT) begin
         decode = sel_filt_low_type;
      end else begin
         decode = sel_none_type;
      end
   endfunction : decode

   assign sel = cmd_valid_in ? decode(wide_link_in, cmd_code_in) : sel_none_type;

   // ****************************************************************
   // Paired value holders
   // ****************************************************************
   // A command for the other value counts as an unrelated command here.
   light_pair_lock raw_pair (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .sample_in(raw_sample_in),
      .sample_valid_in(raw_valid_in),
      .read_high_in(sel == sel_raw_high_type),
      .read_low_in(sel == sel_raw_low_type),
      .other_cmd_in(cmd_valid_in && sel != sel_raw_high_type && sel != sel_raw_low_type),
      .value_out(raw_value)
   );
   light_pair_lock filt_pair (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .sample_in(filt_sample_in),
      .sample_valid_in(filt_valid_in),
      .read_high_in(sel == sel_filt_high_type),
      .read_low_in(sel == sel_filt_low_type),
      .other_cmd_in(cmd_valid_in && sel != sel_filt_high_type && sel != sel_filt_low_type),
      .value_out(filt_value)
   );

   // ****************************************************************
   // Response
   // ****************************************************************
   // Picks the byte before the lock updates, so the read sees the held pair.
   always_comb begin
      case (sel)
         sel_raw_high_type: byte_pick = pick_byte(raw_value, 1'b1);
         sel_raw_low_type: byte_pick = pick_byte(raw_value, 1'b0);
         sel_filt_high_type: byte_pick = pick_byte(filt_value, 1'b1);
         sel_filt_low_type: byte_pick = pick_byte(filt_value, 1'b0);
         default: byte_pick = `SENSOR_BYTE_RESET;
      endcase
      next_cur.valid = (sel != sel_none_type);
      next_cur.data = cur.data;
      if (sel != sel_none_type) begin
         next_cur.data = {`PARAM_UPPER_FILL,
            sense_enable_in ? byte_pick : `SENSOR_BYTE_RESET};
      end
   end

   // Response register.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign rsp_valid_out = cur.valid;
   assign rsp_data_out = cur.data;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_one_cycle_answer;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (cmd_valid_in && sel != sel_none_type) |=> rsp_valid_out;
   endproperty
   a_one_cycle_answer: assert property (p_one_cycle_answer) else $error("no answer");
   property p_disabled_zero;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel != sel_none_type && !sense_enable_in) |=> rsp_data_out == 16'h0000;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("nonzero when off");
   property p_upper_zero;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      rsp_valid_out |-> rsp_data_out[15:8] == 8'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");
   property p_raw_high_data;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel == sel_raw_high_type && sense_enable_in) |=> rsp_data_out[7:0] == $past(raw_value[15:8]);
   endproperty
   a_raw_high_data: assert property (p_raw_high_data) else $error("raw high wrong");
   property p_filt_low_data;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel == sel_filt_low_type && sense_enable_in) |=> rsp_data_out[7:0] == $past(filt_value[7:0]);
   endproperty
   a_filt_low_data: assert property (p_filt_low_data) else $error("filt low wrong");
   property p_no_spurious;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel == sel_none_type) |=> !rsp_valid_out;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("spurious answer");
   property p_reset_clear;
      @(posedge clk_sys_in) !rst_b_in |=> (rsp_data_out == 16'h0000 && raw_value == 16'h0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");
   property p_filt_high_data;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel == sel_filt_high_type && sense_enable_in) |=> rsp_data_out[7:0] == $past(filt_value[15:8]);
   endproperty
   a_filt_high_data: assert property (p_filt_high_data) else $error("filt high wrong");

   // ****************************************************************
   // Pair coherence checks
   // ****************************************************************
   // These look into the two pair holders, so a broken lock shows up here
   // even when the host never reads the damaged byte.

   // A raw low read returns the held low byte.
   property p_raw_low_data;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sel == sel_raw_low_type && sense_enable_in) |=> rsp_data_out[7:0] == $past(raw_value[7:0]);
   endproperty
   a_raw_low_data: assert property (p_raw_low_data) else $error("raw low wrong");

   // The first read of a raw pair leaves both held bytes untouched.
   property p_raw_freeze;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock == lock_free_type && (sel == sel_raw_high_type
         || sel == sel_raw_low_type)) |=> $stable(raw_value);
   endproperty
   a_raw_freeze: assert property (p_raw_freeze) else $error("raw pair moved on read");

   // The first read of a filtered pair leaves both held bytes untouched.
   property p_filt_freeze;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (filt_pair.cur.lock == lock_free_type && (sel == sel_filt_high_type
         || sel == sel_filt_low_type)) |=> $stable(filt_value);
   endproperty
   a_filt_freeze: assert property (p_filt_freeze) else $error("filt pair moved on read");

   // Reading the partner byte of the raw pair frees it.
   property p_raw_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      ((raw_pair.cur.lock == lock_high_read_type && sel == sel_raw_low_type)
         || (raw_pair.cur.lock == lock_low_read_type && sel == sel_raw_high_type))
         |=> raw_pair.cur.lock == lock_free_type;
   endproperty
   a_raw_release: assert property (p_raw_release) else $error("raw pair not freed");

   // Reading the partner byte of the filtered pair frees it.
   property p_filt_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      ((filt_pair.cur.lock == lock_high_read_type && sel == sel_filt_low_type)
         || (filt_pair.cur.lock == lock_low_read_type && sel == sel_filt_high_type))
         |=> filt_pair.cur.lock == lock_free_type;
   endproperty
   a_filt_release: assert property (p_filt_release) else $error("filt pair not freed");

   // A second raw low read pulls the newest high byte in.
   property p_raw_repeat_low;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock == lock_low_read_type && sel == sel_raw_low_type)
         |=> raw_value[15:8] == $past(raw_pair.cur.fresh[15:8]);
   endproperty
   a_raw_repeat_low: assert property (p_raw_repeat_low) else $error("raw high stale");

   // A second filtered low read pulls the newest high byte in.
   property p_filt_repeat_low;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (filt_pair.cur.lock == lock_low_read_type && sel == sel_filt_low_type)
         |=> filt_value[15:8] == $past(filt_pair.cur.fresh[15:8]);
   endproperty
   a_filt_repeat_low: assert property (p_filt_repeat_low) else $error("filt high stale");

   // A second raw high read pulls the newest low byte in.
   property p_raw_repeat_high;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock == lock_high_read_type && sel == sel_raw_high_type)
         |=> raw_value[7:0] == $past(raw_pair.cur.fresh[7:0]);
   endproperty
   a_raw_repeat_high: assert property (p_raw_repeat_high) else $error("raw low stale");

   // A second filtered high read pulls the newest low byte in.
   property p_filt_repeat_high;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (filt_pair.cur.lock == lock_high_read_type && sel == sel_filt_high_type)
         |=> filt_value[7:0] == $past(filt_pair.cur.fresh[7:0]);
   endproperty
   a_filt_repeat_high: assert property (p_filt_repeat_high) else $error("filt low stale");

   // An unknown command frees a locked raw pair.
   property p_raw_other_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock != lock_free_type && cmd_valid_in && sel == sel_none_type)
         |=> raw_pair.cur.lock == lock_free_type;
   endproperty
   a_raw_other_release: assert property (p_raw_other_release) else $error("raw kept");

   // An unknown command frees a locked filtered pair.
   property p_filt_other_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (filt_pair.cur.lock != lock_free_type && cmd_valid_in && sel == sel_none_type)
         |=> filt_pair.cur.lock == lock_free_type;
   endproperty
   a_filt_other_release: assert property (p_filt_other_release) else $error("filt kept");

   // A filtered read counts as unrelated for a locked raw pair.
   property p_raw_cross_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock != lock_free_type && (sel == sel_filt_high_type
         || sel == sel_filt_low_type)) |=> raw_pair.cur.lock == lock_free_type;
   endproperty
   a_raw_cross_release: assert property (p_raw_cross_release) else $error("raw cross");

   // A raw read counts as unrelated for a locked filtered pair.
   property p_filt_cross_release;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (filt_pair.cur.lock != lock_free_type && (sel == sel_raw_high_type
         || sel == sel_raw_low_type)) |=> filt_pair.cur.lock == lock_free_type;
   endproperty
   a_filt_cross_release: assert property (p_filt_cross_release) else $error("filt cross");

   // A free raw pair takes any 16-bit sample unchanged.
   property p_raw_full_range;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (raw_pair.cur.lock == lock_free_type && !cmd_valid_in && raw_valid_in)
         |=> raw_value == $past(raw_sample_in);
   endproperty
   a_raw_full_range: assert property (p_raw_full_range) else $error("raw sample lost");

   // A wide-link code with a nonzero low byte is not a read.
   property p_wide_reject;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (cmd_valid_in && wide_link_in && cmd_code_in[7:0] != 8'h00) |=> !rsp_valid_out;
   endproperty
   a_wide_reject: assert property (p_wide_reject) else $error("bad wide code answered");

   // Reset clears the filtered pair too.
   property p_filt_reset_clear;
      @(posedge clk_sys_in) !rst_b_in |=> filt_value == 16'h0000;
   endproperty
   a_filt_reset_clear: assert property (p_filt_reset_clear) else $error("filt not clear");

   // Main scenarios that the bench should reach.
   c_raw_pair: cover property (@(posedge clk_sys_in) sel == sel_raw_high_type ##1 sel == sel_raw_low_type);
   c_filt_pair: cover property (@(posedge clk_sys_in) sel == sel_filt_low_type ##1 sel == sel_filt_high_type);
   c_low_twice: cover property (@(posedge clk_sys_in) sel == sel_raw_low_type ##1 sel == sel_raw_low_type);
   c_high_twice: cover property (@(posedge clk_sys_in) sel == sel_raw_high_type ##2
      sel == sel_raw_high_type);
   c_sense_off: cover property (@(posedge clk_sys_in) sel != sel_none_type && !sense_enable_in);
endmodule : light_value_readout

// file: src/light_readout_map.svh
`ifndef LIGHT_READOUT_MAP_SVH
`define LIGHT_READOUT_MAP_SVH
// Command codes on the link with a one-byte command field.
`define CMD_RAW_HIGH_SHORT 8'h5a
`define CMD_RAW_LOW_SHORT 8'h5b
`define CMD_FILT_HIGH_SHORT 8'h5c
`define CMD_FILT_LOW_SHORT 8'h5d
// Command addresses on the links with a 16-bit command field.
`define CMD_RAW_HIGH 16'h5a00
`define CMD_RAW_LOW 16'h5b00
`define CMD_FILT_HIGH 16'h5c00
`define CMD_FILT_LOW 16'h5d00
// Reset value of every sensor byte.
`define SENSOR_BYTE_RESET 8'h00
// Filler for the upper parameter byte on 16-bit links.
`define PARAM_UPPER_FILL 8'h00
`endif

// file: src/light_readout_pkg.sv
package light_readout_pkg;
   // Which byte of which value a command selects.
   typedef enum logic [2:0] {
      sel_none_type = 3'h0,
      sel_raw_high_type = 3'h1,
      sel_raw_low_type = 3'h3,
      sel_filt_high_type = 3'h2,
      sel_filt_low_type = 3'h6
   } cmd_sel_type;
   // Lock state of one value pair, coded 0, 1 and 3.
   typedef enum logic [1:0] {
      lock_free_type = 2'h0,
      lock_high_read_type = 2'h1,
      lock_low_read_type = 2'h3
   } lock_state_type;
endpackage : light_readout_pkg

// file: src/light_pair_lock.sv
`timescale 1ns/1ps
`include "light_readout_map.svh"
// Holds one 16-bit value and keeps its two bytes paired across two reads.
module light_pair_lock
   import light_readout_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [15:0] sample_in,
   input wire logic sample_valid_in,
   input wire logic read_high_in,
   input wire logic read_low_in,
   input wire logic other_cmd_in,
   output logic [15:0] value_out
);
   typedef struct packed {
      lock_state_type lock;
      logic [7:0] high_byte;
      logic [7:0] low_byte;
      logic [15:0] fresh;
   } pair_state_type;
   pair_state_type cur;
   pair_state_type next_cur;

   // Lock and update rules for the pair.
   always_comb begin
      next_cur = cur;
      if (sample_valid_in) begin
         next_cur.fresh = sample_in;
      end
      case (cur.lock)
         lock_free_type: begin
            if (read_high_in) begin
               next_cur.lock = lock_high_read_type;
            end else if (read_low_in) begin
               next_cur.lock = lock_low_read_type;
            end else begin
               next_cur.high_byte = next_cur.fresh[15:8];
               next_cur.low_byte = next_cur.fresh[7:0];
            end
         end
         lock_high_read_type: begin
            if (read_low_in || other_cmd_in) begin
               next_cur.lock = lock_free_type;
            end else if (read_high_in) begin
               next_cur.low_byte = cur.fresh[7:0];
            end
         end
         lock_low_read_type: begin
            if (read_high_in || other_cmd_in) begin
               next_cur.lock = lock_free_type;
            end else if (read_low_in) begin
               next_cur.high_byte = cur.fresh[15:8];
            end
         end
         default: begin
            next_cur.lock = lock_free_type;
         end
      endcase
   end

   // State register, cleared to zero by reset.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign value_out = {cur.high_byte, cur.low_byte};

   property p_low_locked;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (cur.lock == lock_high_read_type && !read_low_in && !read_high_in && !other_cmd_in)
         |=> $stable(cur.low_byte);
   endproperty
   a_low_locked: assert property (p_low_locked) else $error("low byte moved while locked");
endmodule : light_pair_lock

// file: dv/light_host_model.sv
`timescale 1ns/1ps
// ****************
// Host side model.
// ****************
// Issues one display command at a time and collects the answer.
module light_host_model (
   input wire logic clk_sys_in,
   input wire logic rsp_valid_in,
   input wire logic [15:0] rsp_data_in,
   output logic cmd_valid_out,
   output logic wide_link_out,
   output logic [15:0] cmd_code_out
);
   // Command lines start idle.
   initial begin
      cmd_valid_out = 1'b0;
      wide_link_out = 1'b1;
      cmd_code_out = 16'h0000;
   end
   // One-cycle command pulse; the answer is taken in the following cycle.
   task automatic issue(input logic wide, input logic [15:0] code, output logic got,
         output logic [15:0] data);
      @(posedge clk_sys_in);
      #1;
      wide_link_out = wide;
      cmd_code_out = code;
      cmd_valid_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      cmd_valid_out = 1'b0;
      cmd_code_out = ~code; // Released code lines must not look valid.
      got = rsp_valid_in;
      data = rsp_data_in;
   endtask : issue
endmodule : light_host_model

// file: dv/ambient_light_value_readout_tb.sv
`timescale 1ns/1ps
// ***********************
// Light readout bench.
// ***********************
module ambient_light_value_readout_tb;
   import light_readout_pkg::*;
   typedef struct packed {logic wide; logic [15:0] code; logic [15:0] exp;} row_type;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic sense_enable_in = 1'b1;
   logic [15:0] raw_sample_in = 16'h0000;
   logic raw_valid_in = 1'b0;
   logic [15:0] filt_sample_in = 16'h0000;
   logic filt_valid_in = 1'b0;
   logic cmd_valid_in;
   logic wide_link_in;
   logic rsp_valid_out;
   logic got;
   logic [15:0] cmd_code_in;
   logic [15:0] rsp_data_out;
   logic [15:0] data;
   int n_fail = 0;
   int total_checks = 0;
   row_type rows [4] = '{'{1'b1, 16'h5a00, 16'h00ff}, '{1'b1, 16'h5b00, 16'h0001},
      '{1'b0, 16'h005c, 16'h0080}, '{1'b0, 16'h005d, 16'h00fe}};
   // Clock of 5 ns period.
   always #2.5 clk_sys_in = ~clk_sys_in;
   light_host_model u_host (.clk_sys_in(clk_sys_in), .rsp_valid_in(rsp_valid_out),
      .rsp_data_in(rsp_data_out), .cmd_valid_out(cmd_valid_in),
      .wide_link_out(wide_link_in), .cmd_code_out(cmd_code_in));
   light_value_readout u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .cmd_valid_in(cmd_valid_in), .wide_link_in(wide_link_in), .cmd_code_in(cmd_code_in),
      .sense_enable_in(sense_enable_in), .raw_sample_in(raw_sample_in),
      .raw_valid_in(raw_valid_in), .filt_sample_in(filt_sample_in),
      .filt_valid_in(filt_valid_in), .rsp_valid_out(rsp_valid_out),
      .rsp_data_out(rsp_data_out));
   // Compares one value and counts it.
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Issues one command through the host model.
   task automatic rd(input logic wide, input logic [15:0] code);
      u_host.issue(wide, code, got, data);
   endtask : rd
   // Presents one new sample of both values for a single cycle.
   task automatic push(input logic [15:0] raw, input logic [15:0] filt);
      @(posedge clk_sys_in);
      #1;
      raw_sample_in = raw;
      filt_sample_in = filt;
      raw_valid_in = 1'b1;
      filt_valid_in = 1'b1;
      @(posedge clk_sys_in);
      #1;
      raw_valid_in = 1'b0;
      filt_valid_in = 1'b0;
   endtask : push
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   // Main sequence: reset, table of plain reads, then the pairing cases.
   initial begin
      repeat (5) @(posedge clk_sys_in);
      #1;
      rst_b_in = 1'b1;
      rd(1'b1, 16'h5a00);
      check("reset high", data, 16'h0000);
      rd(1'b1, 16'h5b00);
      check("read answered", {15'h0000, got}, 16'h0001);
      push(16'hff01, 16'h80fe);
      foreach (rows[i]) begin
         rd(rows[i].wide, rows[i].code);
         check("table read", data, rows[i].exp);
      end
      rd(1'b1, 16'h5a00);
      push(16'h1234, 16'h0000);
      rd(1'b1, 16'h5b00);
      check("frozen low", data, 16'h0001);
      push(16'h5678, 16'h0000);
      rd(1'b1, 16'h5a00);
      check("released high", data, 16'h0056);
      push(16'h9abc, 16'h0000);
      rd(1'b1, 16'h5a00);
      rd(1'b1, 16'h5b00);
      check("low after repeat high", data, 16'h00bc);
      rd(1'b1, 16'h5b00);
      push(16'hdef0, 16'h0000);
      rd(1'b1, 16'h5b00);
      rd(1'b1, 16'h5a00);
      check("high after repeat low", data, 16'h00de);
      rd(1'b1, 16'h5a00);
      rd(1'b1, 16'h5e00);
      check("other gives no answer", {15'h0000, got}, 16'h0000);
      rd(1'b1, 16'h5a01);
      check("bad wide code", {15'h0000, got}, 16'h0000);
      push(16'h4321, 16'h0000);
      rd(1'b1, 16'h5b00);
      check("low after other", data, 16'h0021);
      sense_enable_in = 1'b0;
      rd(1'b1, 16'h5a00);
      check("sensing off high", data, 16'h0000);
      rd(1'b0, 16'h005d);
      check("sensing off low", data, 16'h0000);
      sense_enable_in = 1'b1;
      @(posedge clk_sys_in);
      #1;
      rst_b_in = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      rst_b_in = 1'b1;
      rd(1'b1, 16'h5a00);
      check("second reset", data, 16'h0000);
      final_report();
   end
endmodule : ambient_light_value_readout_tb
